// ### hdl/css_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes pins are asynchronous to core_clk.
`timescale 1ns/1ns
module css_pin_sync
  import css_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // ------------------------------------------------------------
  // Accept a change only when stages two and three agree
  // ------------------------------------------------------------
  always_comb
  begin
    level_next = level_reg;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_reg[i] == s3_reg[i])
      begin
        level_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_reg <= '0;
    end
    else if (ce)
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
endmodule : css_pin_sync

// ### hdl/css_pkg.sv
// Constants for the command source selector.
// Assumes a 32-bit APB register bus and 16-bit command words.
package css_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_P1_FREQ = 8'h04;
  localparam logic [7:0] OFS_P1_FREQ_ALT = 8'h08;
  localparam logic [7:0] OFS_P1_RUN = 8'h0c;
  localparam logic [7:0] OFS_P2_FREQ = 8'h10;
  localparam logic [7:0] OFS_P2_FREQ_ALT = 8'h14;
  localparam logic [7:0] OFS_P2_RUN = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_PARAM = 8'h20;
  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 4;
  localparam int CTRL_LE_ASSIGNED = 4;
  localparam int CTRL_LE_NEGATIVE = 5;
  localparam int CTRL_FB_LSB = 8;
  localparam int CTRL_LOADER_LSB = 12;
  localparam int LINK_MODE_W = 2;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // ------------------------------------------------------------
  // Run word bits and status fields
  // ------------------------------------------------------------
  localparam int RUN_FWD_BIT = 0;
  localparam int RUN_X1_BIT = 2;
  localparam int STAT_FSRC_LSB = 0;
  localparam int STAT_RSRC_LSB = 2;
  localparam int STAT_LINK = 4;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // ------------------------------------------------------------
  // Command sources, link modes and synchroniser depth
  // ------------------------------------------------------------
  localparam logic [1:0] SRC_LOCAL = 2'h0;
  localparam logic [1:0] SRC_P1 = 2'h1;
  localparam logic [1:0] SRC_P2 = 2'h2;
  localparam logic [1:0] SRC_FB = 2'h3;
  localparam logic [1:0] LINK_FOLLOW = 2'h0;
  localparam logic [1:0] LINK_FREQ = 2'h1;
  localparam logic [1:0] LINK_RUN = 2'h2;
  localparam logic [1:0] LINK_BOTH = 2'h3;
  localparam int SYNC_STAGES = 3;
endpackage : css_pkg

// ### hdl/css_selector.sv
// Frequency and run command source selector with APB registers.
// Assumes APB master on core_clk; local frequency and fieldbus words on core_clk.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
// Functional notes
// - With link enable assigned and its input off, commands come from local sources.
// - With the link disabled, local frequency, forward and input one replace the comm words.
// - Parameter data is readable and writable over the link whatever the source mode.
// - The source mode applies only while the link is valid, else sources are local.
// - Modes 0 to 3 select local or port 1 for frequency and run as tabled.
// - Modes 4 to 8 bring port 2 into the frequency and run selection as tabled.
// - Link-delivered digital inputs follow the run command source.
// - Fieldbus and loader link modes override the source mode selection.
// - Without an assigned input, changing the source mode switches like a terminal would.
// - With no input assigned to link enable, the link counts as always enabled.
// - Negative logic inverts the link enable input.
// - Comm command words are cleared at power-up and the host must rewrite them.
// - Comm words are written and held while the link is invalid, used once valid.
module css_selector
  import css_pkg::*;
#(
  parameter int WORD_W = 16
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_enable_input,
  input wire logic forward_run_terminal,
  input wire logic general_input_one,
  input wire logic [WORD_W-1:0] local_freq,
  input wire logic [WORD_W-1:0] fb_freq,
  input wire logic [WORD_W-1:0] fb_run_word,
  output logic [WORD_W-1:0] freq_cmd,
  output logic run_forward,
  output logic input_one,
  output logic [1:0] freq_src,
  output logic [1:0] run_src,
  output logic link_valid,
  output logic [WORD_W-1:0] param_word
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] mode_decode(input logic [3:0] mode);
    case (mode)
      4'h0: mode_decode = {SRC_LOCAL, SRC_LOCAL};
      4'h1: mode_decode = {SRC_P1, SRC_LOCAL};
      4'h2: mode_decode = {SRC_LOCAL, SRC_P1};
      4'h3: mode_decode = {SRC_P1, SRC_P1};
      4'h4: mode_decode = {SRC_P2, SRC_LOCAL};
      4'h5: mode_decode = {SRC_P2, SRC_P1};
      4'h6: mode_decode = {SRC_LOCAL, SRC_P2};
      4'h7: mode_decode = {SRC_P1, SRC_P2};
      4'h8: mode_decode = {SRC_P2, SRC_P2};
      default: mode_decode = {SRC_LOCAL, SRC_LOCAL};
    endcase
  endfunction : mode_decode

  function automatic logic [WORD_W-1:0] pick_freq(input logic [WORD_W-1:0] main_w,
                                                  input logic [WORD_W-1:0] alt_w);
    pick_freq = (alt_w != '0) ? alt_w : main_w;
  endfunction : pick_freq

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] pins_sync;
  logic le_sync;
  logic fwd_sync;
  logic x1_sync;

  css_pin_sync #(.WIDTH(3)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .pin_in({link_enable_input, forward_run_terminal, general_input_one}),
    .level_out(pins_sync)
  );
  assign le_sync = pins_sync[2];
  assign fwd_sync = pins_sync[1];
  assign x1_sync = pins_sync[0];

  // ------------------------------------------------------------
  // APB register file
  // ------------------------------------------------------------
  logic [15:0] ctrl_reg, ctrl_next;
  logic [WORD_W-1:0] p1_freq_reg, p1_freq_next;
  logic [WORD_W-1:0] p1_alt_reg, p1_alt_next;
  logic [WORD_W-1:0] p1_run_reg, p1_run_next;
  logic [WORD_W-1:0] p2_freq_reg, p2_freq_next;
  logic [WORD_W-1:0] p2_alt_reg, p2_alt_next;
  logic [WORD_W-1:0] p2_run_reg, p2_run_next;
  logic [WORD_W-1:0] param_reg, param_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic wr_fire;
  logic mapped;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  assign wr_fire = psel && penable && pready_reg && pwrite;

  always_comb
  begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_word = {16'h0000, ctrl_reg};
      OFS_P1_FREQ: rd_word = 32'(p1_freq_reg);
      OFS_P1_FREQ_ALT: rd_word = 32'(p1_alt_reg);
      OFS_P1_RUN: rd_word = 32'(p1_run_reg);
      OFS_P2_FREQ: rd_word = 32'(p2_freq_reg);
      OFS_P2_FREQ_ALT: rd_word = 32'(p2_alt_reg);
      OFS_P2_RUN: rd_word = 32'(p2_run_reg);
      OFS_STATUS: rd_word = status_word;
      OFS_PARAM: rd_word = 32'(param_reg);
      default: mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    ctrl_next = ctrl_reg;
    p1_freq_next = p1_freq_reg;
    p1_alt_next = p1_alt_reg;
    p1_run_next = p1_run_reg;
    p2_freq_next = p2_freq_reg;
    p2_alt_next = p2_alt_reg;
    p2_run_next = p2_run_reg;
    param_next = param_reg;
    pready_next = psel && penable && !pready_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (psel && penable && !pready_reg)
    begin
      prdata_next = pwrite ? 32'h0000_0000 : rd_word;
      pslverr_next = !mapped;
    end
    if (wr_fire)
    begin
      // Comm words stored regardless of link state
      case (paddr)
        OFS_CTRL: ctrl_next = pwdata[15:0];
        OFS_P1_FREQ: p1_freq_next = pwdata[WORD_W-1:0];
        OFS_P1_FREQ_ALT: p1_alt_next = pwdata[WORD_W-1:0];
        OFS_P1_RUN: p1_run_next = pwdata[WORD_W-1:0];
        OFS_P2_FREQ: p2_freq_next = pwdata[WORD_W-1:0];
        OFS_P2_FREQ_ALT: p2_alt_next = pwdata[WORD_W-1:0];
        OFS_P2_RUN: p2_run_next = pwdata[WORD_W-1:0];
        OFS_PARAM: param_next = pwdata[WORD_W-1:0];
        default: param_next = param_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RESET;
      p1_freq_reg <= WORD_RESET;
      p1_alt_reg <= WORD_RESET;
      p1_run_reg <= WORD_RESET;
      p2_freq_reg <= WORD_RESET;
      p2_alt_reg <= WORD_RESET;
      p2_run_reg <= WORD_RESET;
      param_reg <= WORD_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_reg <= ctrl_next;
      p1_freq_reg <= p1_freq_next;
      p1_alt_reg <= p1_alt_next;
      p1_run_reg <= p1_run_next;
      p2_freq_reg <= p2_freq_next;
      p2_alt_reg <= p2_alt_next;
      p2_run_reg <= p2_run_next;
      param_reg <= param_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ------------------------------------------------------------
  // Source selection
  // ------------------------------------------------------------
  logic [3:0] src_mode;
  logic le_assigned;
  logic le_negative;
  logic [1:0] fb_mode;
  logic [1:0] loader_mode;
  logic link_next;
  logic [3:0] base_src;
  logic [1:0] fsrc_next, rsrc_next;
  logic [WORD_W-1:0] freq_next;
  logic [WORD_W-1:0] run_word;
  logic fwd_next, x1_next;
  logic [WORD_W-1:0] freq_reg;
  logic fwd_reg, x1_reg;
  logic [1:0] fsrc_reg, rsrc_reg;
  logic link_reg;

  assign src_mode = ctrl_reg[CTRL_MODE_LSB +: CTRL_MODE_W];
  assign le_assigned = ctrl_reg[CTRL_LE_ASSIGNED];
  assign le_negative = ctrl_reg[CTRL_LE_NEGATIVE];
  assign fb_mode = ctrl_reg[CTRL_FB_LSB +: LINK_MODE_W];
  assign loader_mode = ctrl_reg[CTRL_LOADER_LSB +: LINK_MODE_W];
  assign status_word = {27'h0000000, link_reg, rsrc_reg, fsrc_reg};

  always_comb
  begin
    // Unassigned input means link always on polarity
    link_next = le_assigned ? (le_sync ^ le_negative) : 1'b1;
    // Mode applies only with a valid link
    base_src = link_next ? mode_decode(src_mode) : {SRC_LOCAL, SRC_LOCAL};
    fsrc_next = base_src[3:2];
    rsrc_next = base_src[1:0];
    // Fieldbus then loader take precedence
    if (fb_mode == LINK_FREQ || fb_mode == LINK_BOTH)
    begin
      fsrc_next = SRC_FB;
    end
    if (fb_mode == LINK_RUN || fb_mode == LINK_BOTH)
    begin
      rsrc_next = SRC_FB;
    end
    if (loader_mode == LINK_FREQ || loader_mode == LINK_BOTH)
    begin
      fsrc_next = SRC_P1;
    end
    if (loader_mode == LINK_RUN || loader_mode == LINK_BOTH)
    begin
      rsrc_next = SRC_P1;
    end
    case (fsrc_next)
      SRC_P1: freq_next = pick_freq(p1_freq_reg, p1_alt_reg);
      SRC_P2: freq_next = pick_freq(p2_freq_reg, p2_alt_reg);
      SRC_FB: freq_next = fb_freq;
      default: freq_next = local_freq;
    endcase
    case (rsrc_next)
      SRC_P1: run_word = p1_run_reg;
      SRC_P2: run_word = p2_run_reg;
      SRC_FB: run_word = fb_run_word;
      default: run_word = WORD_RESET;
    endcase
    // Link digital inputs ride with the run source
    fwd_next = (rsrc_next == SRC_LOCAL) ? fwd_sync : run_word[RUN_FWD_BIT];
    x1_next = (rsrc_next == SRC_LOCAL) ? x1_sync : run_word[RUN_X1_BIT];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      freq_reg <= WORD_RESET;
      fwd_reg <= 1'b0;
      x1_reg <= 1'b0;
      fsrc_reg <= SRC_LOCAL;
      rsrc_reg <= SRC_LOCAL;
      link_reg <= 1'b0;
    end
    else if (ce)
    begin
      freq_reg <= freq_next;
      fwd_reg <= fwd_next;
      x1_reg <= x1_next;
      fsrc_reg <= fsrc_next;
      rsrc_reg <= rsrc_next;
      link_reg <= link_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign freq_cmd = freq_reg;
  assign run_forward = fwd_reg;
  assign input_one = x1_reg;
  assign freq_src = fsrc_reg;
  assign run_src = rsrc_reg;
  assign link_valid = link_reg;
  assign param_word = param_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic no_override;
  assign no_override = (fb_mode == LINK_FOLLOW) && (loader_mode == LINK_FOLLOW);

  a_le_off_local: assert property (
    (ce && le_assigned && !le_negative && !le_sync && no_override)
      |=> (fsrc_reg == SRC_LOCAL) && (rsrc_reg == SRC_LOCAL))
    else $error("link input off did not select local");
  a_local_run_pins: assert property (
    (ce && rsrc_next == SRC_LOCAL) |=> (fwd_reg == $past(fwd_sync)) && (x1_reg == $past(x1_sync)))
    else $error("local run pins not passed");
  a_param_write: assert property (
    (ce && wr_fire && paddr == OFS_PARAM) |=> param_reg == $past(pwdata[WORD_W-1:0]))
    else $error("parameter write lost");
  a_mode_gated: assert property (
    (ce && !link_next && no_override) |=> fsrc_reg == SRC_LOCAL && rsrc_reg == SRC_LOCAL)
    else $error("mode applied with invalid link");
  a_mode_three: assert property (
    (ce && link_next && no_override && src_mode == 4'h3)
      |=> fsrc_reg == SRC_P1 && rsrc_reg == SRC_P1 && freq_cmd == $past(freq_next))
    else $error("mode 3 decode wrong");
  a_mode_seven: assert property (
    (ce && link_next && no_override && src_mode == 4'h7) |=> fsrc_reg == SRC_P1 && rsrc_reg == SRC_P2)
    else $error("mode 7 decode wrong");
  a_x1_follows_run: assert property (
    (ce && rsrc_next == SRC_P2) |=> x1_reg == $past(p2_run_reg[RUN_X1_BIT]))
    else $error("input one not from port 2 run word");
  a_loader_wins: assert property (
    (ce && loader_mode == LINK_BOTH) |=> fsrc_reg == SRC_P1 && rsrc_reg == SRC_P1)
    else $error("loader mode did not override");
  a_unassigned_link: assert property (
    (ce && !rst && !le_assigned) |=> link_reg)
    else $error("link not permanent without input");
  a_negative_le: assert property (
    (ce && le_assigned && le_negative) |=> link_reg == !$past(le_sync))
    else $error("negative logic not inverted");
  a_reset_clear: assert property (
    $past(rst) |-> p1_run_reg == WORD_RESET && p2_run_reg == WORD_RESET)
    else $error("command words not cleared");
  a_store_invalid: assert property (
    (ce && wr_fire && paddr == OFS_P1_RUN && !link_reg) |=> p1_run_reg == $past(pwdata[WORD_W-1:0]))
    else $error("write lost while link invalid");

  c_both_port2: cover property (ce && fsrc_reg == SRC_P2 && rsrc_reg == SRC_P2);
  c_link_drop: cover property (ce && $fell(link_reg));
  c_fieldbus: cover property (ce && rsrc_reg == SRC_FB);
endmodule : css_selector

// ### tb/css_host_model.sv
// Host controller model: APB master that writes the command words.
// Assumes one clock, core_clk, shared with the selector.
`timescale 1ns/1ns
module css_host_model
  import css_pkg::*;
(
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic hang
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hang = 1'b0;
  end
  // ------------------------------------------------------------
  // One transfer, held until pready
  // ------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      hang <= 1'b1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
  endtask : xfer
  // ------------------------------------------------------------
  // Command words rewritten after power-on
  // ------------------------------------------------------------
  task automatic init_words;
    logic [31:0] r;
    logic e;
    xfer(1'b1, OFS_P1_FREQ, 32'h1111, r, e);
    xfer(1'b1, OFS_P1_RUN, 32'h0001, r, e);
    xfer(1'b1, OFS_P2_FREQ, 32'h2222, r, e);
    xfer(1'b1, OFS_P2_RUN, 32'h0004, r, e);
  endtask : init_words
endmodule : css_host_model

// ### tb/css_selector_tb.sv
// Testbench for the command source selector.
// Assumes the host model drives APB; pins and local words are driven here.
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module css_selector_tb
  import css_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, hang, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ce = 1'b1;
  logic link_enable_input = 1'b0;
  logic forward_run_terminal = 1'b0;
  logic general_input_one = 1'b0;
  logic [15:0] local_freq = 16'h0aaa;
  logic [15:0] fb_freq = 16'h0bbb;
  logic [15:0] fb_run_word = 16'h0004;
  logic [15:0] freq_cmd, param_word;
  logic run_forward, input_one, link_valid;
  logic [1:0] freq_src, run_src;
  int num_errors = 0;
  int total_checks = 0;
  localparam logic [1:0] FT [0:8] = '{SRC_LOCAL, SRC_P1, SRC_LOCAL, SRC_P1, SRC_P2,
                                      SRC_P2, SRC_LOCAL, SRC_P1, SRC_P2};
  localparam logic [1:0] RT [0:8] = '{SRC_LOCAL, SRC_LOCAL, SRC_P1, SRC_P1, SRC_LOCAL,
                                      SRC_P1, SRC_P2, SRC_P2, SRC_P2};
  always #20 core_clk = ~core_clk;
  css_selector css_selector_i (.core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_enable_input(link_enable_input),
    .forward_run_terminal(forward_run_terminal), .general_input_one(general_input_one),
    .local_freq(local_freq), .fb_freq(fb_freq), .fb_run_word(fb_run_word),
    .freq_cmd(freq_cmd), .run_forward(run_forward), .input_one(input_one),
    .freq_src(freq_src), .run_src(run_src), .link_valid(link_valid),
    .param_word(param_word));
  css_host_model css_host_model_i (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hang(hang));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    css_host_model_i.xfer(1'b1, a, {16'h0000, d}, rd, err);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    css_host_model_i.xfer(1'b0, a, 32'h0, rd, err);
    `CHK(nm, exp, rd)
  endtask : rd_chk
  task automatic chk_out(input logic [1:0] fs, input logic [1:0] rs, input logic [15:0] f,
                         input logic fw, input logic x1);
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("freq_src", fs, freq_src)
    `CHK("run_src", rs, run_src)
    `CHK("freq_cmd", f, freq_cmd)
    `CHK("run_forward", fw, run_forward)
    `CHK("input_one", x1, input_one)
    @(posedge core_clk);
  endtask : chk_out
  function automatic logic [15:0] fexp(input logic [1:0] s);
    return (s == SRC_P1) ? 16'h1111 : ((s == SRC_P2) ? 16'h2222 : local_freq);
  endfunction : fexp
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    for (int a = 4; a <= 32; a += 4)
      if (a != 28)
        rd_chk("word", 8'(a), 32'h0);
    chk_out(SRC_LOCAL, SRC_LOCAL, local_freq, 1'b0, 1'b0);
    `CHK("link_valid", 1'b1, link_valid)
    rd_chk("unmapped", 8'h24, 32'h0);
    `CHK("pslverr", 1'b1, err)
  endtask : t_reset
  task automatic t_modes;
    css_host_model_i.init_words();
    for (int m = 0; m <= 8; m++)
    begin
      wr(OFS_CTRL, 16'(m));
      chk_out(FT[m], RT[m], fexp(FT[m]), RT[m] == SRC_P1, RT[m] == SRC_P2);
      rd_chk("status", OFS_STATUS, {27'h0, 1'b1, RT[m], FT[m]});
    end
  endtask : t_modes
  task automatic t_link;
    forward_run_terminal <= 1'b1;
    general_input_one <= 1'b1;
    wr(OFS_CTRL, 16'h0013);
    chk_out(SRC_LOCAL, SRC_LOCAL, local_freq, 1'b1, 1'b1);
    `CHK("link_valid", 1'b0, link_valid)
    wr(OFS_P1_FREQ, 16'h3333);
    chk_out(SRC_LOCAL, SRC_LOCAL, local_freq, 1'b1, 1'b1);
    link_enable_input <= 1'b1;
    chk_out(SRC_P1, SRC_P1, 16'h3333, 1'b1, 1'b0);
    wr(OFS_CTRL, 16'h0033);
    chk_out(SRC_LOCAL, SRC_LOCAL, local_freq, 1'b1, 1'b1);
    wr(OFS_PARAM, 16'h5a5a);
    rd_chk("param", OFS_PARAM, 32'h5a5a);
    `CHK("param_word", 16'h5a5a, param_word)
    link_enable_input <= 1'b0;
    chk_out(SRC_P1, SRC_P1, 16'h3333, 1'b1, 1'b0);
  endtask : t_link
  task automatic t_override;
    wr(OFS_CTRL, 16'h0300);
    chk_out(SRC_FB, SRC_FB, fb_freq, fb_run_word[0], fb_run_word[2]);
    link_enable_input <= 1'b1;
    wr(OFS_CTRL, 16'h1030);
    chk_out(SRC_P1, SRC_LOCAL, 16'h3333, 1'b1, 1'b1);
  endtask : t_override
  task automatic t_freeze;
    ce <= 1'b0;
    forward_run_terminal <= 1'b0;
    chk_out(SRC_P1, SRC_LOCAL, 16'h3333, 1'b1, 1'b1);
    ce <= 1'b1;
    chk_out(SRC_P1, SRC_LOCAL, 16'h3333, 1'b0, 1'b1);
  endtask : t_freeze
  task automatic t_power;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk("p1_freq", OFS_P1_FREQ, 32'h0);
    rd_chk("p1_run", OFS_P1_RUN, 32'h0);
  endtask : t_power
  // ------------------------------------------------------------
  // Sequence and verdict
  // ------------------------------------------------------------
  task automatic final_report;
    $display("total_checks %0d num_errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  always @(posedge hang)
  begin
    num_errors++;
    final_report();
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_link();
    t_override();
    t_freeze();
    t_power();
    final_report();
  end
endmodule : css_selector_tb
